/* logic/dab_decoder.sv */
// Instruction decoder for add, logic, product and branch groups
`default_nettype none
module dab_decoder
   import dab_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic [15:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   input wire dab_pkg::dab_flags_s FLAGS_I,
   input wire logic TEST_FLAG_I,
   input wire logic AUX_NONZERO_I,
   input wire logic IO_BRANCH_INPUT_I,
   output logic DONE_O,
   output logic SECOND_WORD_O,
   output dab_pkg::dab_dec_s DEC_O
);
   import dab_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic hit(
      input logic [15:0] w,
      input logic [15:0] m,
      input logic [15:0] p
   );
      hit = ((w & m) == p);
   endfunction

   function automatic logic [2:0] branch_cycles(
      input logic tk,
      input logic [2:0] miss
   );
      branch_cycles = tk ? CYC_FOUR : miss;
   endfunction

   // Priority decode: full patterns before partial ones
   function automatic dab_op_e classify(
      input logic [15:0] x
   );
      if (hit(x, M_FULL, PAT_ABS)) begin
         classify = OP_ABS;
      end else if (hit(x, M_FULL, PAT_PRODUCT_ACCUMULATE_OP)) begin
         classify = OP_PROD_ACC;
      end else if (hit(x, M_FULL, PAT_JUMP_TO_ACCUM_OP)) begin
         classify = OP_JUMP_ACC;
      end else if (hit(x, M_FULL, PAT_AND16)) begin
         classify = OP_AND_IMM16;
      end else if (hit(x, M_B12, PAT_ADDLK)) begin
         classify = OP_ADD_LONG;
      end else if (hit(x, M_B12, PAT_ANDK)) begin
         classify = OP_AND_IMM;
      end else if (hit(x, M_B8, PAT_ADDSK)) begin
         classify = OP_ADD_SHORT;
      end else if (hit(x, M_B8, PAT_AUX_POINTER_INCREMENT_OP)) begin
         classify = OP_AUX_INC;
      end else if (hit(x, M_B8, PAT_JUMP_AUX_NONZERO_OP)) begin
         classify = OP_JUMP_AUX;
      end else if (hit(x, M_B8, PAT_SUM_WITH_CARRY_OP)) begin
         classify = OP_ADD_CARRY;
      end else if (hit(x, M_B8, PAT_ADDH)) begin
         classify = OP_ADD_HIGH;
      end else if (hit(x, M_B8, PAT_SUM_NO_SIGN_EXTEND_OP)) begin
         classify = OP_ADD_NOSIGN;
      end else if (hit(x, M_B8, PAT_SUM_TREG_SHIFT_OP)) begin
         classify = OP_ADD_TSHIFT;
      end else if (hit(x, M_B8, PAT_ANDM)) begin
         classify = OP_AND_MEM;
      end else if (hit(x, M_B4, PAT_ADD)) begin
         classify = OP_ADD_SHIFT;
      end else if (hit(x, M_B6, PAT_CONDITIONAL_JUMP_OP)) begin
         classify = OP_COND_JUMP;
      end else begin
         classify = OP_NONE;
      end
   endfunction

   // Forms that carry a second word
   function automatic logic needs_second(
      input dab_op_e op
   );
      unique case (op)
         OP_AND_IMM16, OP_ADD_LONG, OP_AND_IMM, OP_JUMP_AUX, OP_COND_JUMP: needs_second = 1'b1;
         default: needs_second = 1'b0;
      endcase
   endfunction

   // Selector pair: io input low, flag set, flag clear, none
   function automatic logic sel_cond(
      input logic [1:0] s,
      input logic io_low,
      input logic tflag
   );
      unique case (s)
         SEL_IO: sel_cond = io_low;
         SEL_TSET: sel_cond = tflag;
         SEL_TCLR: sel_cond = ~tflag;
         2'h3: sel_cond = 1'b0;
      endcase
   endfunction

   // Masked conditions only; unmasked bits drop out
   function automatic logic mask_match(
      input logic [3:0] mask,
      input logic [3:0] state_bits,
      input logic [3:0] flags
   );
      mask_match = |(mask & ~(flags ^ state_bits));
   endfunction

   // Shift field: bits 11:8 for plain add, fixed 16 for one AND form
   function automatic logic [3:0] pick_shift(
      input dab_op_e op,
      input logic [15:0] x
   );
      unique case (op)
         OP_ADD_SHIFT: pick_shift = x[SHIFT_HI_LSB +: 4];
         OP_AND_IMM16: pick_shift = SHIFT_SIXTEEN;
         default: pick_shift = x[3:0];
      endcase
   endfunction

   // Execution cycles; conditional branches depend on the outcome
   function automatic logic [2:0] cycle_count(
      input dab_op_e op,
      input logic tk,
      input logic io_sel
   );
      unique case (op)
         OP_JUMP_ACC: cycle_count = CYC_FOUR;
         OP_JUMP_AUX: cycle_count = branch_cycles(tk, CYC_TWO);
         OP_COND_JUMP: cycle_count = branch_cycles(tk, io_sel ? CYC_THREE : CYC_TWO);
         OP_ADD_LONG, OP_AND_IMM, OP_AND_IMM16: cycle_count = CYC_TWO;
         default: cycle_count = CYC_ONE;
      endcase
   endfunction

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   logic io_meta;
   logic io_sync;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         io_meta <= 1'b1;
         io_sync <= 1'b1;
      end else begin
         io_meta <= IO_BRANCH_INPUT_I;
         io_sync <= io_meta;
      end
   end

   // ----------------------------------------
   // Opcode classification
   // ----------------------------------------
   wire logic [15:0] w = INSTR_I;
   wire logic is_abs = hit(w, M_FULL, PAT_ABS);
   wire logic is_product_accumulate_op = hit(w, M_FULL, PAT_PRODUCT_ACCUMULATE_OP);
   wire logic is_jump_to_accum_op = hit(w, M_FULL, PAT_JUMP_TO_ACCUM_OP);
   wire logic is_and16 = hit(w, M_FULL, PAT_AND16);
   wire logic is_addlk = hit(w, M_B12, PAT_ADDLK);
   wire logic is_andk = hit(w, M_B12, PAT_ANDK);
   wire logic is_addsk = hit(w, M_B8, PAT_ADDSK);
   wire logic is_aux_pointer_increment_op = hit(w, M_B8, PAT_AUX_POINTER_INCREMENT_OP);
   wire logic is_jump_aux_nonzero_op = hit(w, M_B8, PAT_JUMP_AUX_NONZERO_OP);
   wire logic is_sum_with_carry_op = hit(w, M_B8, PAT_SUM_WITH_CARRY_OP);
   wire logic is_addh = hit(w, M_B8, PAT_ADDH);
   wire logic is_sum_no_sign_extend_op = hit(w, M_B8, PAT_SUM_NO_SIGN_EXTEND_OP);
   wire logic is_sum_treg_shift_op = hit(w, M_B8, PAT_SUM_TREG_SHIFT_OP);
   wire logic is_andm = hit(w, M_B8, PAT_ANDM);
   wire logic is_add = hit(w, M_B4, PAT_ADD);
   wire logic is_conditional_jump_op = hit(w, M_B6, PAT_CONDITIONAL_JUMP_OP);

   wire dab_op_e op_first = classify(w);

   wire logic two_word = needs_second(op_first);

   // ----------------------------------------
   // Condition evaluation
   // ----------------------------------------
   wire logic [1:0] sel = w[SEL_LSB +: 2];
   wire logic [3:0] cmask = w[3:0];
   wire logic [3:0] cstate = w[STATE_LSB +: 4];
   wire logic [3:0] flag_vec = FLAGS_I;
   wire logic flag_condition_group_met = mask_match(cmask, cstate, flag_vec);
   wire logic sel_met = sel_cond(sel, ~io_sync, TEST_FLAG_I);
   wire logic cond_met = sel_met | flag_condition_group_met;
   wire logic io_form = (sel == SEL_IO);
   wire logic conditional_jump_op_tk = cond_met;
   wire logic jump_aux_nonzero_op_tk = AUX_NONZERO_I;

   wire logic first_tk = (is_conditional_jump_op & conditional_jump_op_tk)
      | (is_jump_aux_nonzero_op & jump_aux_nonzero_op_tk) | is_jump_to_accum_op;

   wire logic [2:0] first_cyc = cycle_count(op_first, first_tk, io_form);

   wire logic [3:0] first_shift = pick_shift(op_first, w);

   // ----------------------------------------
   // First-word decode record
   // ----------------------------------------
   wire dab_dec_s first_dec = '{
      op: op_first,
      words: two_word ? WORDS_TWO : WORDS_ONE,
      cycles: first_cyc,
      taken: first_tk,
      cond_met: is_conditional_jump_op & cond_met,
      shift: first_shift,
      addr: w[7:0],
      imm: {8'h00, w[7:0]}
   };

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic {
      ST_FIRST,
      ST_SECOND
   } dab_state_e;

   dab_state_e state;
   dab_state_e next_state;
   dab_dec_s pend;
   dab_dec_s next_pend;
   dab_dec_s next_dec;
   logic next_done;

   always_comb begin
      next_state = state;
      next_pend = pend;
      next_dec = DEC_O;
      next_done = 1'b0;
      unique case (state)
         ST_FIRST: begin
            if (INSTR_VALID_I) begin
               next_pend = first_dec;
               if (two_word) begin
                  next_state = ST_SECOND;
               end else begin
                  next_dec = next_pend;
                  next_done = 1'b1;
               end
            end
         end
         ST_SECOND: begin
            if (INSTR_VALID_I) begin
               next_dec = pend;
               next_dec.imm = w;
               next_done = 1'b1;
               next_state = ST_FIRST;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         state <= ST_FIRST;
         pend <= '0;
      end else begin
         state <= next_state;
         pend <= next_pend;
      end
   end

   // ----------------------------------------
   // Output register
   // ----------------------------------------
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         DEC_O <= '0;
         DONE_O <= 1'b0;
         SECOND_WORD_O <= 1'b0;
      end else begin
         DEC_O <= next_dec;
         DONE_O <= next_done;
         SECOND_WORD_O <= (next_state == ST_SECOND);
      end
   end
endmodule
`default_nettype wire

/* logic/dab_pkg.sv */
// Package: opcode patterns, counts and carriers for the decoder
`default_nettype none
package dab_pkg;
   // ----------------------------------------
   // Opcode match values and masks
   // ----------------------------------------
   localparam logic [15:0] M_FULL = 16'hFFFF;
   localparam logic [15:0] M_B12 = 16'hFFF0;
   localparam logic [15:0] M_B8 = 16'hFF00;
   localparam logic [15:0] M_B6 = 16'hFC00;
   localparam logic [15:0] M_B4 = 16'hF000;
   localparam logic [15:0] PAT_ABS = 16'hBE00;
   localparam logic [15:0] PAT_PRODUCT_ACCUMULATE_OP = 16'hBE04;
   localparam logic [15:0] PAT_JUMP_TO_ACCUM_OP = 16'hBE20;
   localparam logic [15:0] PAT_AND16 = 16'hBE81;
   localparam logic [15:0] PAT_ADDLK = 16'hBF90;
   localparam logic [15:0] PAT_ANDK = 16'hBFB0;
   localparam logic [15:0] PAT_ADDSK = 16'hB800;
   localparam logic [15:0] PAT_AUX_POINTER_INCREMENT_OP = 16'h7800;
   localparam logic [15:0] PAT_JUMP_AUX_NONZERO_OP = 16'h7B00;
   localparam logic [15:0] PAT_SUM_WITH_CARRY_OP = 16'h6000;
   localparam logic [15:0] PAT_ADDH = 16'h6100;
   localparam logic [15:0] PAT_SUM_NO_SIGN_EXTEND_OP = 16'h6200;
   localparam logic [15:0] PAT_SUM_TREG_SHIFT_OP = 16'h6300;
   localparam logic [15:0] PAT_ANDM = 16'h6E00;
   localparam logic [15:0] PAT_ADD = 16'h2000;
   localparam logic [15:0] PAT_CONDITIONAL_JUMP_OP = 16'hE000;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SEL_LSB = 8;
   localparam int STATE_LSB = 4;
   localparam int SHIFT_HI_LSB = 8;
   localparam logic [1:0] SEL_IO = 2'h0;
   localparam logic [1:0] SEL_TSET = 2'h1;
   localparam logic [1:0] SEL_TCLR = 2'h2;
   // ----------------------------------------
   // Word and cycle counts
   // ----------------------------------------
   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;
   localparam logic [3:0] SHIFT_SIXTEEN = 4'h0;

   typedef enum logic [4:0] {
      OP_NONE, OP_ABS, OP_ADD_SHIFT, OP_ADD_HIGH, OP_ADD_SHORT,
      OP_ADD_LONG, OP_ADD_CARRY, OP_ADD_NOSIGN, OP_ADD_TSHIFT,
      OP_AUX_INC, OP_AND_MEM, OP_AND_IMM, OP_AND_IMM16,
      OP_PROD_ACC, OP_JUMP_ACC, OP_JUMP_AUX, OP_COND_JUMP
   } dab_op_e;

   // Flag group: zero, negative, overflow, carry (msb first)
   typedef struct packed {
      logic zero;
      logic neg;
      logic ovf;
      logic carry;
   } dab_flags_s;

   typedef struct packed {
      dab_op_e op;
      logic [1:0] words;
      logic [2:0] cycles;
      logic taken;
      logic cond_met;
      logic [3:0] shift;
      logic [7:0] addr;
      logic [15:0] imm;
   } dab_dec_s;
endpackage
`default_nettype wire

/* test/dab_decoder_props.sv */
// Port checker for the decoder
`default_nettype none
module dab_decoder_props
   import dab_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic [15:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   input wire dab_pkg::dab_flags_s FLAGS_I,
   input wire logic TEST_FLAG_I,
   input wire logic AUX_NONZERO_I,
   input wire logic IO_BRANCH_INPUT_I,
   input wire logic DONE_O,
   input wire logic SECOND_WORD_O,
   input wire dab_pkg::dab_dec_s DEC_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   wire logic opc = INSTR_VALID_I && !SECOND_WORD_O;
   property dec1(m, p, o);
      opc && (INSTR_I & m) == p |=> DONE_O && DEC_O.op == o && DEC_O.words == 2'h1;
   endproperty
   a_abs_decode: assert property (dec1(16'hFFFF, 16'hBE00, OP_ABS)) else $error("abs");
   a_prod_decode: assert property (dec1(16'hFFFF, 16'hBE04, OP_PROD_ACC)) else $error("prod");
   a_aux_decode: assert property (dec1(16'hFF00, 16'h7800, OP_AUX_INC)) else $error("aux add");
   a_jacc_cycles: assert property (opc && INSTR_I == 16'hBE20 |=> DEC_O.op == OP_JUMP_ACC && DEC_O.cycles == 3'h4)
      else $error("acc jump");
   a_add_fields: assert property (opc && INSTR_I[15:12] == 4'h2 |=> DEC_O.op == OP_ADD_SHIFT &&
      DEC_O.shift == $past(INSTR_I[11:8]) && DEC_O.addr == $past(INSTR_I[7:0])) else $error("add fields");
   a_two_word: assert property (opc && INSTR_I[15:8] == 8'h7B |=> SECOND_WORD_O && !DONE_O) else $error("wait");
   a_second_imm: assert property (INSTR_VALID_I && SECOND_WORD_O |=> DONE_O && DEC_O.imm == $past(INSTR_I))
      else $error("second word");
   a_aux_cycles: assert property (DONE_O && DEC_O.op == OP_JUMP_AUX |-> DEC_O.cycles == (DEC_O.taken ? 3'h4 : 3'h2))
      else $error("aux cycles");
   a_cond_cycles: assert property (DONE_O && DEC_O.op == OP_COND_JUMP && DEC_O.taken |-> DEC_O.cycles == 3'h4)
      else $error("cond cycles");
   cover property (DONE_O && DEC_O.op == OP_COND_JUMP && !DEC_O.taken);
   cover property (DONE_O && DEC_O.op == OP_JUMP_AUX && DEC_O.taken);
   cover property (DONE_O && DEC_O.op == OP_AND_IMM16);
endmodule
bind dab_decoder dab_decoder_props u_dab_decoder_props (.SYS_CLK_I, .RSTN_I, .INSTR_I, .INSTR_VALID_I, .FLAGS_I,
   .TEST_FLAG_I, .AUX_NONZERO_I, .IO_BRANCH_INPUT_I, .DONE_O, .SECOND_WORD_O, .DEC_O);
`default_nettype wire

/* test/dab_pmem.sv */
// Program memory model feeding instruction words
`default_nettype none
module dab_pmem (
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic [15:0] word_i,
   output logic valid_o,
   output logic [15:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last = 16'h0000;
   always @(posedge clk_i) if (rd_i) last <= word_i;
   // Idle bus shows inverse of last word
   assign valid_o = rd_i;
   assign word_o = rd_i ? word_i : ~last;
endmodule
`default_nettype wire

/* test/test_dab_decoder.sv */
// Bench for the decoder
`default_nettype none
module test_dab_decoder
   import dab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, tf = 1'b0, aux = 1'b0, io = 1'b1, done, sec, vld;
   logic [15:0] wd = 16'h0000, instr;
   dab_flags_s fl = 4'h0;
   dab_dec_s dec;
   int mismatches = 0, comparisons = 0;
   logic [15:0] ow [12] = '{16'hBE00, 16'hBE04, 16'hBE20, 16'h2A5C, 16'hB8F1, 16'h783C, 16'h6012, 16'h6134,
      16'h6256, 16'h6378, 16'h6E9A, 16'h0000};
   dab_op_e oo [12] = '{OP_ABS, OP_PROD_ACC, OP_JUMP_ACC, OP_ADD_SHIFT, OP_ADD_SHORT, OP_AUX_INC, OP_ADD_CARRY,
      OP_ADD_HIGH, OP_ADD_NOSIGN, OP_ADD_TSHIFT, OP_AND_MEM, OP_NONE};
   logic [15:0] tw [3] = '{16'hBF95, 16'hBFB3, 16'hBE81};
   dab_op_e tp [3] = '{OP_ADD_LONG, OP_AND_IMM, OP_AND_IMM16};
   logic [7:0] cc [8] = '{8'h00, 8'h8C, 8'h04, 8'hCC, 8'h44, 8'h11, 8'h01, 8'h02};
   always #2 clk = ~clk;
   dab_pmem u_dab_pmem (.clk_i(clk), .rd_i(rd), .word_i(wd), .valid_o(vld), .word_o(instr));
   dab_decoder u_dab_decoder (.SYS_CLK_I(clk), .RSTN_I(rstn), .INSTR_I(instr), .INSTR_VALID_I(vld), .FLAGS_I(fl),
      .TEST_FLAG_I(tf), .AUX_NONZERO_I(aux), .IO_BRANCH_INPUT_I(io), .DONE_O(done), .SECOND_WORD_O(sec), .DEC_O(dec));
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Conditions settle first, io input needs its two-flop lag
   task run(input logic [15:0] w1, input logic [15:0] w2, input logic two, input logic [6:0] cnd);
      @(posedge clk);
      {io, aux, tf, fl} <= cnd;
      repeat (3) @(posedge clk);
      rd <= 1'b1;
      wd <= w1;
      if (two) begin
         @(posedge clk);
         wd <= w2;
         #1 chk(sec, 1'b1);
      end
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(done, 1'b1);
   endtask
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
   initial begin
      logic [3:0] f;
      logic t;
      logic [39:0] e;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      #1 chk(dec, 40'h0);
      for (int i = 0; i < 12; i++) begin
         run(ow[i], 16'h0000, 1'b0, 7'h40);
         e = {oo[i], 2'h1, (oo[i] == OP_JUMP_ACC) ? 3'h4 : 3'h1, ow[i][7:0], 8'h00, ow[i][7:0]};
         chk({dec.op, dec.words, dec.cycles, dec.addr, dec.imm}, e);
         if (oo[i] == OP_ADD_SHIFT) chk(dec.shift, ow[i][11:8]);
      end
      $display("test one_word done");
      for (int i = 0; i < 3; i++) begin
         run(tw[i], 16'h1234, 1'b1, 7'h40);
         e = {tp[i], 2'h2, 3'h2, (i == 2) ? 4'h0 : tw[i][3:0], 16'h1234};
         chk({dec.op, dec.words, dec.cycles, dec.shift, dec.imm}, e);
      end
      for (int k = 0; k < 2; k++) begin
         run(16'h7B10, 16'h0040, 1'b1, {1'b1, k[0], 1'b0, 4'h0});
         e = {OP_JUMP_AUX, k[0], k[0] ? 3'h4 : 3'h2, 8'h10, 16'h0040};
         chk({dec.op, dec.taken, dec.cycles, dec.addr, dec.imm}, e);
      end
      $display("test two_word done");
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
               f = 4'(k * 5);
               t = |(cc[c][3:0] & ~(f ^ cc[c][7:4])) | (s == 0 && !k[0]) | (s == 1 && k[1]) | (s == 2 && !k[1]);
               run({6'h38, s[1:0], cc[c]}, 16'h0C35, 1'b1, {k[0], 1'b0, k[1], f});
               e = {OP_COND_JUMP, t, t, t ? 3'h4 : (s == 0) ? 3'h3 : 3'h2, 16'h0C35};
               chk({dec.op, dec.taken, dec.cond_met, dec.cycles, dec.imm}, e);
            end
         end
      end
      $display("test cond_jump done");
      stop_test;
   end
endmodule
`default_nettype wire
